// ==== rtl/tblr_top.sv ====
`timescale 1ns/10ps
// Operation
// RULE1: A table read loads the fetched word's upper byte into table-high.
// RULE2: Table-high is read-only; software writes never change it.
// RULE3: Every table instruction takes exactly two cycles and stalls the next.
// RULE4: Normal reads address memory with high pointer over low pointer.
// RULE5: The read address covers the whole 2K-word program memory.
// RULE6: Software should avoid table reads in both main code and handlers.
// RULE7: A table read writes the low byte to the operand data location.
// RULE8: Last-page reads use the top page with the low pointer only.
module tblr_top (
  input  wire logic                            mclk_i,
  input  wire logic                            rst_i,
  input  wire logic                            rd_req_i,
  input  wire logic                            rd_last_i,
  input  wire logic [tblr_pkg::DM_ADDR_W-1:0]  dst_addr_i,
  input  wire logic [tblr_pkg::LOW_PTR_W-1:0]  low_ptr_i,
  input  wire logic [tblr_pkg::HIGH_PTR_W-1:0] high_ptr_i,
  input  wire logic                            thb_wr_i,
  input  wire logic [7:0]                      thb_wdata_i,
  input  wire logic                            pm_wr_en_i,
  input  wire logic [tblr_pkg::PM_ADDR_W-1:0]  pm_wr_addr_i,
  input  wire logic [tblr_pkg::PM_DATA_W-1:0]  pm_wr_data_i,
  output logic                                 stall_o,
  output logic                                 busy_o,
  output logic                                 dm_we_o,
  output logic [tblr_pkg::DM_ADDR_W-1:0]       dm_addr_o,
  output logic [7:0]                           dm_wdata_o,
  output logic [7:0]                           table_high_byte_o
);
  ////////////////////////////////////////////////////////////////////////
  // Every check below samples on the system clock and rests during reset.
  default clocking chk_cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  // Length of one table instruction in cycles, as the checks count it.
  localparam logic [1:0] CYC_N = 2'(tblr_pkg::TBL_CYCLES);

  tblr_pm_if pm ();

  tblr_pkg::tblr_state_e            state_ff;
  tblr_pkg::tblr_state_e            nxt_state;
  logic [tblr_pkg::DM_ADDR_W-1:0]   dst_ff;
  logic [7:0]                       thb_ff;
  logic                             stall_ff;
  logic                             busy_ff;
  logic                             dm_we_ff;
  logic [tblr_pkg::DM_ADDR_W-1:0]   dm_addr_ff;
  logic [7:0]                       dm_wdata_ff;
  wire  [tblr_pkg::HIGH_PTR_W-1:0]  page_sel;
  wire  [tblr_pkg::PM_ADDR_W-1:0]   req_addr;
  wire                              start;
  wire                              finish;
  wire  [7:0]                       fetch_hi;
  wire  [7:0]                       fetch_lo;
  logic [1:0]                       cyc_ff;

  // Refuses a package that asks for other than a two-cycle instruction.
  if (tblr_pkg::TBL_CYCLES != 2) begin : g_cyc_chk
    $error("tblr_top: TBL_CYCLES must be 2.");
  end

  // Picks one byte of a program word: the upper one when hi is set.
  function automatic logic [7:0] pick_byte(
    input logic [tblr_pkg::PM_DATA_W-1:0] word,
    input logic                           hi
  );
    pick_byte = hi ? word[15:8] : word[7:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Address formation: page bits over the low pointer byte.
  assign page_sel = rd_last_i ? tblr_pkg::LAST_PAGE : high_ptr_i; // [RULE8]
  assign req_addr = {page_sel, low_ptr_i}; // [RULE4] [RULE5]
  assign start    = (state_ff == tblr_pkg::TBLR_IDLE) && rd_req_i;
  assign finish   = (state_ff == tblr_pkg::TBLR_FETCH);

  // Memory read is issued in the first cycle of the instruction.
  assign pm.rd_en = start;
  assign pm.addr  = req_addr;

  // Byte split of the registered program word.
  assign fetch_hi = pick_byte(pm.rdata, 1'b1); // [RULE1]
  assign fetch_lo = pick_byte(pm.rdata, 1'b0); // [RULE7]

  tblr_pmem #(
    .DEPTH (1 << tblr_pkg::PM_ADDR_W)
  ) u_pmem (
    .mclk_i    (mclk_i),
    .pm        (pm),
    .wr_en_i   (pm_wr_en_i),
    .wr_addr_i (pm_wr_addr_i),
    .wr_data_i (pm_wr_data_i)
  );

  ////////////////////////////////////////////////////////////////////////
  // Two-cycle sequence: issue, then capture the word.
  always_comb begin
    case (state_ff)
      tblr_pkg::TBLR_IDLE:  nxt_state = rd_req_i ? tblr_pkg::TBLR_FETCH
                                                 : tblr_pkg::TBLR_IDLE;
      tblr_pkg::TBLR_FETCH: nxt_state = tblr_pkg::TBLR_IDLE; // [RULE3]
      default:              nxt_state = tblr_pkg::TBLR_IDLE;
    endcase
  end

  // State, captured operands and stall flag.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state_ff <= tblr_pkg::TBLR_IDLE;
      dst_ff   <= '0;
      stall_ff <= 1'b0;
      busy_ff  <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      stall_ff <= start; // Holds the next instruction one cycle. [RULE3]
      busy_ff  <= start;
      if (start) begin
        dst_ff  <= dst_addr_i;
      end
    end
  end

  // Results: low byte to data memory, high byte to table-high.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      thb_ff      <= tblr_pkg::TBL_HIGH_RST;
      dm_we_ff    <= 1'b0;
      dm_addr_ff  <= '0;
      dm_wdata_ff <= '0;
    end else begin
      dm_we_ff <= finish; // [RULE7]
      if (finish) begin
        thb_ff      <= fetch_hi; // [RULE1]
        dm_addr_ff  <= dst_ff; // [RULE7]
        dm_wdata_ff <= fetch_lo; // [RULE7]
      end
      // Software writes to table-high are discarded. [RULE2]
    end
  end

  // Counts the cycles of the read in flight, so the checks can time it.
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      cyc_ff <= 2'h0;
    end else if (start) begin
      cyc_ff <= 2'h1;
    end else if (cyc_ff == CYC_N) begin
      cyc_ff <= 2'h0;
    end else if (cyc_ff != 2'h0) begin
      cyc_ff <= cyc_ff + 2'h1;
    end
  end

  assign stall_o           = stall_ff;
  assign busy_o            = busy_ff;
  assign dm_we_o           = dm_we_ff;
  assign dm_addr_o         = dm_addr_ff;
  assign dm_wdata_o        = dm_wdata_ff;
  assign table_high_byte_o = thb_ff;

  ////////////////////////////////////////////////////////////////////////
  // Checks. A request is taken on the edge that sees start; the stall
  // stands in the next cycle and the results land in the one after.
  sequence req_s;
    start;
  endsequence

  sequence stall_s;
    stall_o && busy_o && (state_ff == tblr_pkg::TBLR_FETCH);
  endsequence

  sequence done_s;
    !stall_o && dm_we_o;
  endsequence

  // The instruction takes exactly two cycles: stall, then results.
  two_cycle_a: assert property ( // [RULE3]
    req_s |=> stall_s ##1 done_s)
    else $error("Table read did not complete in two cycles.");

  // The following instruction is held while the word is fetched.
  stall_next_a: assert property ( // [RULE3]
    start |=> stall_o && state_ff == tblr_pkg::TBLR_FETCH)
    else $error("Next instruction not stalled.");

  // A request seen during the stall cycle starts nothing.
  stall_refuse_a: assert property ( // [RULE3]
    stall_s |=> !stall_o && !busy_o)
    else $error("Request accepted during the stall cycle.");

  // Results arrive at the count of cycles that the instruction takes.
  cycle_count_a: assert property ( // [RULE3]
    dm_we_o |-> cyc_ff == CYC_N)
    else $error("Table read result arrived at the wrong cycle.");

  // The upper byte of the fetched word lands in table-high.
  high_load_a: assert property ( // [RULE1]
    finish |=> table_high_byte_o == $past(pm.rdata[15:8]))
    else $error("Table-high not loaded.");

  // Table-high moves only on a table read.
  high_ro_a: assert property ( // [RULE2]
    !finish |=> $stable(table_high_byte_o))
    else $error("Table-high changed without a table read.");

  // A software write never puts its own value into table-high.
  sw_write_a: assert property ( // [RULE2]
    (thb_wr_i && !finish && thb_wdata_i != table_high_byte_o)
      |=> table_high_byte_o != $past(thb_wdata_i))
    else $error("Software write reached table-high.");

  // The low byte goes to the operand location named with the request.
  low_store_a: assert property ( // [RULE7]
    start |-> ##2 (dm_addr_o == $past(dst_addr_i, 2)))
    else $error("Low byte sent to wrong location.");

  // The data written is the lower byte of the fetched word.
  low_data_a: assert property ( // [RULE7]
    finish |=> dm_wdata_o == $past(pm.rdata[7:0]))
    else $error("Low byte of the word not written.");

  // Destination and data stay put until the next table read.
  result_hold_a: assert property ( // [RULE7]
    !finish |=> $stable(dm_addr_o) && $stable(dm_wdata_o))
    else $error("Table read results changed between reads.");

  // The data memory write strobe is a single-cycle pulse.
  we_pulse_a: assert property ( // [RULE7]
    dm_we_o |=> !dm_we_o)
    else $error("Data write lasted more than one cycle.");

  // A last-page read addresses the top page, whatever the high pointer.
  last_page_a: assert property ( // [RULE8]
    (start && rd_last_i) |-> pm.addr == {tblr_pkg::LAST_PAGE, low_ptr_i})
    else $error("Last-page read used wrong page.");

  // A normal read puts the high pointer over the low pointer.
  norm_addr_a: assert property ( // [RULE4]
    (start && !rd_last_i) |-> pm.addr == {high_ptr_i, low_ptr_i})
    else $error("Normal read address wrong.");
endmodule

// ==== rtl/tblr_pkg.sv ====
package tblr_pkg;
  // Program memory geometry: 2K words of 16 bits.
  localparam int unsigned PM_ADDR_W   = 11;
  localparam int unsigned PM_DATA_W   = 16;
  localparam int unsigned LOW_PTR_W   = 8;
  localparam int unsigned HIGH_PTR_W  = PM_ADDR_W - LOW_PTR_W;
  localparam int unsigned DM_ADDR_W   = 8;
  // Uppermost page number used by the last-page read.
  localparam logic [HIGH_PTR_W-1:0] LAST_PAGE = 3'h7;
  // Reset value of the table-high register.
  localparam logic [7:0] TBL_HIGH_RST = 8'h00;
  // Instruction cycles taken by every table instruction.
  localparam int unsigned TBL_CYCLES  = 2;
  // Sequencer states.
  typedef enum logic [1:0] {
    TBLR_IDLE  = 2'b00,
    TBLR_FETCH = 2'b01,
    TBLR_DONE  = 2'b10
  } tblr_state_e;
endpackage

// ==== rtl/tblr_pm_if.sv ====
`timescale 1ns/10ps
// Program memory read port between the reader and its memory.
interface tblr_pm_if;
  logic                              rd_en;
  logic [tblr_pkg::PM_ADDR_W-1:0]    addr;
  logic [tblr_pkg::PM_DATA_W-1:0]    rdata;
  modport master (output rd_en, output addr, input rdata);
  modport slave  (input rd_en, input addr, output rdata);
endinterface

// ==== rtl/tblr_pmem.sv ====
`timescale 1ns/10ps
// Program memory with registered read data and a load port.
module tblr_pmem #(
  parameter int unsigned DEPTH = 2048
) (
  input  wire logic                           mclk_i,
  tblr_pm_if.slave                            pm,
  input  wire logic                           wr_en_i,
  input  wire logic [tblr_pkg::PM_ADDR_W-1:0] wr_addr_i,
  input  wire logic [tblr_pkg::PM_DATA_W-1:0] wr_data_i
);
  logic [tblr_pkg::PM_DATA_W-1:0] mem [DEPTH];
  logic [tblr_pkg::PM_DATA_W-1:0] rdata_ff;

  // Refuses a depth that the address width cannot reach exactly.
  if (DEPTH != (1 << tblr_pkg::PM_ADDR_W)) begin : g_depth_chk
    $error("tblr_pmem: DEPTH must match the address width.");
  end

  // Writes load code; reads come out one cycle later from a register.
  always_ff @(posedge mclk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
    if (pm.rd_en) begin
      rdata_ff <= mem[pm.addr];
    end
  end

  assign pm.rdata = rdata_ff;
endmodule

// ==== verification/tblr_ref_mem.sv ====
`timescale 1ns/10ps
// Reference program memory, filled from the same load port as the design.
module tblr_ref_mem (
  input  wire logic                           mclk_i,
  input  wire logic                           wr_en_i,
  input  wire logic [tblr_pkg::PM_ADDR_W-1:0] wr_addr_i,
  input  wire logic [tblr_pkg::PM_DATA_W-1:0] wr_data_i
);
  // The whole 2K-word space is held, so any word can be table data.
  logic [tblr_pkg::PM_DATA_W-1:0] mem [2**tblr_pkg::PM_ADDR_W];

  // Words are taken on the edge at which the design writes them.
  always_ff @(posedge mclk_i) begin
    if (wr_en_i) begin
      mem[wr_addr_i] <= wr_data_i;
    end
  end
endmodule

// ==== verification/tb_top.sv ====
`timescale 1ns/10ps
module tb_top;
  logic        mclk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        rd_req_i = 1'b0;
  logic        rd_last_i = 1'b0;
  logic        thb_wr_i = 1'b0;
  logic        pm_wr_en_i = 1'b0;
  logic [7:0]  dst_addr_i = 8'h00;
  logic [7:0]  low_ptr_i = 8'h00;
  logic [2:0]  high_ptr_i = 3'h0;
  logic [7:0]  thb_wdata_i = 8'h00;
  logic [10:0] pm_wr_addr_i = 11'h000;
  logic [15:0] pm_wr_data_i = 16'h0000;
  logic        stall_o, busy_o, dm_we_o;
  logic [7:0]  dm_addr_o, dm_wdata_o, table_high_byte_o, last_hi;
  logic [23:0] e;
  logic [23:0] exp_q[$];
  realtime     t_q[$];
  realtime     t0;
  // Request drive edge to mid-result, in tenths of a nanosecond.
  localparam int LAT = tblr_pkg::TBL_CYCLES * 250 + 125;
  int          bad_count = 0;
  int          num_checks = 0;

  tblr_top u_tblr_top (.mclk_i(mclk_i), .rst_i(rst_i), .rd_req_i(rd_req_i),
    .rd_last_i(rd_last_i), .dst_addr_i(dst_addr_i), .low_ptr_i(low_ptr_i),
    .high_ptr_i(high_ptr_i), .thb_wr_i(thb_wr_i), .thb_wdata_i(thb_wdata_i),
    .pm_wr_en_i(pm_wr_en_i), .pm_wr_addr_i(pm_wr_addr_i),
    .pm_wr_data_i(pm_wr_data_i), .stall_o(stall_o), .busy_o(busy_o),
    .dm_we_o(dm_we_o), .dm_addr_o(dm_addr_o), .dm_wdata_o(dm_wdata_o),
    .table_high_byte_o(table_high_byte_o));
  tblr_ref_mem u_tblr_ref_mem (.mclk_i(mclk_i), .wr_en_i(pm_wr_en_i),
    .wr_addr_i(pm_wr_addr_i), .wr_data_i(pm_wr_data_i));

  // Free-running 40 MHz clock.
  initial begin
    forever #12.5 mclk_i = ~mclk_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Compares one value and counts it.
  task automatic chk(input string nm, input logic [15:0] x, g);
    num_checks++;
    if (g !== x) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, x, g);
    end
  endtask

  // Issues one read; the stall cycle carries a junk request to be ignored.
  task automatic rd(input logic l, input logic [7:0] lp, input logic [2:0] hp);
    logic [10:0] a;
    logic [7:0]  d;
    a = l ? {tblr_pkg::LAST_PAGE, lp} : {hp, lp};
    d = 8'($urandom);
    @(posedge mclk_i);
    rd_req_i <= 1'b1;
    rd_last_i <= l;
    low_ptr_i <= lp;
    high_ptr_i <= hp;
    dst_addr_i <= d;
    thb_wr_i <= 1'($urandom);
    thb_wdata_i <= 8'($urandom);
    exp_q.push_back({d, u_tblr_ref_mem.mem[a]});
    t_q.push_back($realtime);
    @(posedge mclk_i);
    rd_req_i <= 1'($urandom);
    low_ptr_i <= 8'($urandom);
    dst_addr_i <= 8'($urandom);
    @(negedge mclk_i);
    chk("stall_busy", 16'h0003, {14'h0, stall_o, busy_o});
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0 && exp_q.size() == 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Takes the oldest note whenever a data memory write appears.
  always @(negedge mclk_i) begin
    if (dm_we_o === 1'b1) begin
      e = exp_q.pop_front();
      last_hi = e[15:8];
      chk("dm_addr_o", 16'(e[23:16]), 16'(dm_addr_o));
      chk("dm_wdata_o", 16'(e[7:0]), 16'(dm_wdata_o));
      chk("table_high", 16'(e[15:8]), 16'(table_high_byte_o));
      t0 = t_q.pop_front();
      chk("latency", 16'(LAT), 16'(int'(($realtime - t0) * 10)));
      chk("stall_o", 16'h0000, 16'(stall_o));
    end
  end

  // Cuts a hang short.
  initial begin
    repeat (6000) @(posedge mclk_i);
    bad_count++;
    $display("Error watchdog expected done seen timeout");
    end_of_test();
  end

  // Main sequence; reads come from one stream only, never a handler.
  initial begin
    void'($urandom(32'hEBAA));
    repeat (12) @(posedge mclk_i);
    chk("outputs", 16'h0000, {13'h0, stall_o, busy_o, dm_we_o});
    chk("table_high", 16'(tblr_pkg::TBL_HIGH_RST), 16'(table_high_byte_o));
    rst_i <= 1'b0;
    for (int i = 0; i < 2048; i++) begin
      @(posedge mclk_i);
      pm_wr_en_i <= 1'b1;
      pm_wr_addr_i <= 11'(i);
      pm_wr_data_i <= 16'($urandom);
    end
    @(posedge mclk_i);
    pm_wr_en_i <= 1'b0;
    $display("test reset and load done");
    rd(1'b0, 8'h00, 3'h0);
    rd(1'b0, 8'hFF, 3'h7);
    repeat (40) rd(1'b0, 8'($urandom), 3'($urandom));
    $display("test normal reads done");
    repeat (24) rd(1'b1, 8'($urandom), 3'($urandom));
    @(posedge mclk_i);
    rd_req_i <= 1'b0;
    repeat (4) @(posedge mclk_i);
    $display("test last page reads done");
    repeat (8) begin
      @(posedge mclk_i);
      thb_wr_i <= 1'b1;
      thb_wdata_i <= ~last_hi;
    end
    @(posedge mclk_i);
    thb_wr_i <= 1'b0;
    @(negedge mclk_i);
    chk("table_high", 16'(last_hi), 16'(table_high_byte_o));
    $display("test table high write done");
    end_of_test();
  end
endmodule
